// ===== ssal_regs.svh
// Purpose: Offsets, field positions and codes of the save-area layout
// Assumes: Byte offsets are relative to the save-area base
// Notes: 128-bit beats; field positions are bit LSBs within a beat
`ifndef SSAL_REGS_SVH
`define SSAL_REGS_SVH
// ****************************************
// Area map
// ****************************************
`define SSAL_HDR_OFS 12'h200
`define SSAL_EXT_OFS 12'h240
`define SSAL_BEAT_BYTES 12'h010
`define SSAL_ALIGN_MASK 32'h0000003f
`define SSAL_COMPACT_BIT 63
// ****************************************
// Beat indices of one walk
// ****************************************
`define SSAL_B_LEG0 6'h00
`define SSAL_B_LEG1 6'h01
`define SSAL_B_STK0 6'h02
`define SSAL_B_V128L 6'h0a
`define SSAL_B_V128H 6'h12
`define SSAL_B_HDR 6'h1a
`define SSAL_B_EXT0 6'h1b
`define SSAL_B_EXT8 6'h23
`define SSAL_B_LAST 6'h2a
// ****************************************
// Field LSBs within legacy beats
// ****************************************
`define SSAL_F_CTLW 0
`define SSAL_F_STSW 16
`define SSAL_F_TAG 32
`define SSAL_F_OPC 48
`define SSAL_F_PTR 64
`define SSAL_F_SEL 96
`define SSAL_F_SEL1 32
`define SSAL_F_VCS 64
`define SSAL_F_VCMASK 96
// ****************************************
// Byte strobes and codes
// ****************************************
`define SSAL_S_LEG0_W 16'hffdf
`define SSAL_S_LEG0_N 16'h3fdf
`define SSAL_S_LEG1_FW 16'h00ff
`define SSAL_S_LEG1_FN 16'h003f
`define SSAL_S_LEG1_V128 16'hff00
`define SSAL_S_STK 16'h03ff
`define SSAL_S_FULL 16'hffff
`define SSAL_TAG_EMPTY 2'h3
`define SSAL_TAG_VALID 2'h0
`define SSAL_TAG_ZERO 2'h1
`define SSAL_TAG_SPECIAL 2'h2
`define SSAL_EXP_MAX 15'h7fff
`endif

// ===== ssal_pkg.sv
// Purpose: Types shared by the save-area layout block
// Assumes: 64-bit addresses, 128-bit memory beats
// Notes: Carried as packed structs
package ssal_pkg;
	typedef enum logic {SSAL_OP_SAVE, SSAL_OP_RESTORE} ssal_op_e;
	typedef struct packed {
		ssal_op_e op;
		logic wide;
		logic long_mode;
		logic [63:0] base;
		logic [63:0] req_mask;
		logic [63:0] compaction_bitmap;
	} ssal_cmd_s;
	typedef struct packed {
		logic wr;
		logic [63:0] addr;
		logic [127:0] data;
		logic [15:0] strb;
	} ssal_beat_s;
	typedef struct packed {
		logic [15:0] fp_control_word;
		logic [15:0] fp_status_word;
		logic [15:0] fp_tag_word;
		logic [15:0] fp_last_opcode;
		logic [63:0] fp_instr_pointer;
		logic [15:0] fp_code_selector;
		logic [63:0] fp_data_pointer;
		logic [15:0] fp_data_selector;
		logic [31:0] simd_ctrl_status;
	} ssal_fp_s;
endpackage

// ===== ssal_layout.sv
// Purpose: Save-area address generation and formatting for save and restore
// Assumes: In-order single response per read beat; base is 64-byte aligned
// Notes: Beats leave through a FIFO to the load/store path
//
// Behaviour
// (RL1) Extended region begins at byte 576 of the area.
// (RL2) Only components two and above live in the extended region.
// (RL3) Compaction bitmap bit 63 selects compacted versus standard layout.
// (RL4) Standard layout uses enumerated per-component offset and size.
// (RL5) Compacted layout allocates nothing for components with clear bitmap bit.
// (RL6) First present compacted component sits at byte 576.
// (RL7) Later compacted components follow previous one, optionally 64-byte aligned.
// (RL8) Component state starts at byte 0 of its section.
// (RL9) Control word bytes 1:0, status 3:2, last opcode 7:6.
// (RL10) Byte 4 holds abridged tag, one bit per non-empty stack register.
// (RL11) Restore marks register empty when abridged bit is zero, else derives.
// (RL12) Instruction pointer and code selector placement depend on wide prefix.
// (RL13) Data pointer and data selector placement depend on wide prefix.
// (RL14) Stack registers in bytes 159:32, low 80 bits of 128-bit slots.
// (RL15) Stack state save-area work only with the save-enable bit set.
// (RL16) Control/status at bytes 27:24; reserved bits on restore fault.
// (RL17) Mask value saved at bytes 31:28, ignored on restore.
// (RL18) 128-bit registers 8-15 are touched only in 64-bit mode.
// (RL19) 128-bit state managed only with save-enable and mask bit 1.
// (RL20) Upper half i at bytes 16i; upper eight only in 64-bit mode.
// (RL21) Wide-vector work refused unless save-enable and mask bit 2.
// (RL22) Mask bit 0 always reads as one.
// (RL23) Software supplies a 64-byte aligned area base.
// (RL24) Header of 64 bytes at offset 512 holds the bitmaps.
`timescale 1ns/1ps
`include "ssal_regs.svh"

// ****************************************
// Beat FIFO
// ****************************************
module ssal_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic push;
	logic pop;

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin
			$error("ssal_fifo depth must be a power of two");
		end
	end

	// Honest full and empty from pointer compare
	assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
	assign out_valid = (wp_r != rp_r);
	assign out_data = mem_r[rp_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage write
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule

// ****************************************
// Layout engine
// ****************************************
module ssal_layout #(
	parameter int NCOMP = 10,
	parameter int FIFO_DEPTH = 32,
	parameter logic [31:0] VCS_VALID = 32'h0000ffff
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic save_enable_bit,
	input wire logic [63:0] user_state_enable_mask,
	input wire logic sel_deprecated,
	input wire logic [31:0] enum_offset [NCOMP],
	input wire logic [31:0] enum_size [NCOMP],
	input wire logic enum_align [NCOMP],
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire ssal_pkg::ssal_cmd_s cmd,
	input wire ssal_pkg::ssal_fp_s fp_state,
	input wire logic [79:0] fp_stack_regs [8],
	input wire logic [127:0] simd128_regs [16],
	input wire logic [127:0] simd256_upper_halves [16],
	output logic mem_valid,
	input wire logic mem_ready,
	output ssal_pkg::ssal_beat_s mem_beat,
	input wire logic rsp_valid,
	input wire logic [127:0] rsp_data,
	output logic op_done,
	output logic op_fault,
	output logic wide_vector_allowed,
	output logic [63:0] user_enable_mask_alias,
	output logic [31:0] comp_location [NCOMP],
	output ssal_pkg::ssal_fp_s rest_fp,
	output logic rf_wr_valid,
	output logic [5:0] rf_wr_idx,
	output logic [127:0] rf_wr_data
);
	import ssal_pkg::*;

	typedef enum logic [1:0] {SSAL_IDLE, SSAL_RUN, SSAL_WAIT, SSAL_DONE} ssal_state_e;

	ssal_state_e state_r;
	ssal_cmd_s cmd_r;
	logic [5:0] idx_r;
	logic [31:0] ext_loc_r;
	logic fp_en_r, v128_en_r, v256_en_r;
	logic fault_r;
	logic [7:0] abr_r;
	logic [63:0] mask_eff;
	logic [31:0] loc_w [NCOMP];
	logic active_w;
	logic push_w;
	logic fifo_ready;
	logic last_w;
	logic rsp_fire;
	logic bad_vcs;
	ssal_beat_s beat_w;

	initial begin
		if (NCOMP < 3 || NCOMP > 63) begin
			$error("ssal_layout NCOMP out of range");
		end
	end

	// (RL22) Bit 0 forced high
	assign mask_eff = user_state_enable_mask | 64'h0000000000000001;
	assign user_enable_mask_alias = mask_eff;
	// (RL21) Wide-vector gate
	assign wide_vector_allowed = save_enable_bit && mask_eff[2];
	assign cmd_ready = (state_r == SSAL_IDLE);
	assign op_done = (state_r == SSAL_DONE);
	assign op_fault = fault_r;
	assign last_w = (idx_r == `SSAL_B_LAST);
	assign rsp_fire = (state_r == SSAL_WAIT) && rsp_valid;

	// Component locations for both layouts
	always_comb begin
		logic [31:0] run;
		logic first;
		run = 32'h0;
		first = 1'b1;
		for (int i = 0; i < NCOMP; i++) begin
			loc_w[i] = 32'h0;
			if (i >= 2) begin
				if (!cmd.compaction_bitmap[`SSAL_COMPACT_BIT]) begin
					// (RL3) (RL4) Standard: enumerated offset
					loc_w[i] = enum_offset[i];
				end else if (cmd.compaction_bitmap[i]) begin
					if (first) begin
						// (RL1) (RL6) First present at 576
						loc_w[i] = 32'(`SSAL_EXT_OFS);
					end else if (enum_align[i]) begin
						// (RL7) Round up to 64
						loc_w[i] = (run + `SSAL_ALIGN_MASK) & ~`SSAL_ALIGN_MASK;
					end else begin
						loc_w[i] = run;
					end
					// (RL5) Only present components take space
					run = loc_w[i] + enum_size[i];
					first = 1'b0;
				end
			end
		end
	end

	// Which beats of the walk take part
	always_comb begin
		// Ranges overlap, so the first matching item wins
		priority case (1'b1)
			(idx_r == `SSAL_B_LEG0): active_w = fp_en_r;
			(idx_r == `SSAL_B_LEG1): active_w = fp_en_r || v128_en_r;
			(idx_r < `SSAL_B_V128L): active_w = fp_en_r;
			// (RL18) Upper registers only in 64-bit mode
			(idx_r < `SSAL_B_V128H): active_w = v128_en_r;
			(idx_r < `SSAL_B_HDR): active_w = v128_en_r && cmd_r.long_mode;
			(idx_r == `SSAL_B_HDR): active_w = (cmd_r.op == SSAL_OP_SAVE);
			// (RL20) Upper halves 8-15 only in 64-bit mode
			(idx_r < `SSAL_B_EXT8): active_w = v256_en_r;
			default: active_w = v256_en_r && cmd_r.long_mode;
		endcase
	end

	// Beat address, data and strobes
	always_comb begin
		logic [63:0] ofs;
		beat_w = '0;
		ofs = 64'h0;
		beat_w.wr = (cmd_r.op == SSAL_OP_SAVE);
		if (idx_r < `SSAL_B_HDR) begin
			ofs = 64'(idx_r) * 64'(`SSAL_BEAT_BYTES);
		end else if (idx_r == `SSAL_B_HDR) begin
			// (RL24) Header at 512
			ofs = 64'(`SSAL_HDR_OFS);
		end else begin
			// (RL8) Component state from byte 0 of its section
			ofs = 64'(ext_loc_r) + 64'(idx_r - `SSAL_B_EXT0) * 64'(`SSAL_BEAT_BYTES);
		end
		// (RL23) Base taken as aligned
		beat_w.addr = {cmd_r.base[63:6], 6'h00} + ofs;
		if (idx_r == `SSAL_B_LEG0) begin
			// (RL9) Control, status, opcode
			beat_w.data[`SSAL_F_CTLW +: 16] = fp_state.fp_control_word;
			beat_w.data[`SSAL_F_STSW +: 16] = fp_state.fp_status_word;
			beat_w.data[`SSAL_F_OPC +: 16] = fp_state.fp_last_opcode;
			// (RL10) Abridged tag byte
			for (int j = 0; j < 8; j++) begin
				beat_w.data[`SSAL_F_TAG + j] = (fp_state.fp_tag_word[2*j +: 2] != `SSAL_TAG_EMPTY);
			end
			// (RL12) Instruction pointer and selector
			if (cmd_r.wide) begin
				beat_w.data[`SSAL_F_PTR +: 64] = fp_state.fp_instr_pointer;
				beat_w.strb = `SSAL_S_LEG0_W;
			end else begin
				beat_w.data[`SSAL_F_PTR +: 32] = fp_state.fp_instr_pointer[31:0];
				beat_w.data[`SSAL_F_SEL +: 16] = sel_deprecated ? 16'h0000 : fp_state.fp_code_selector;
				beat_w.strb = `SSAL_S_LEG0_N;
			end
		end else if (idx_r == `SSAL_B_LEG1) begin
			// (RL13) Data pointer and selector
			if (cmd_r.wide) begin
				beat_w.data[0 +: 64] = fp_state.fp_data_pointer;
				beat_w.strb = fp_en_r ? `SSAL_S_LEG1_FW : 16'h0000;
			end else begin
				beat_w.data[0 +: 32] = fp_state.fp_data_pointer[31:0];
				beat_w.data[`SSAL_F_SEL1 +: 16] = sel_deprecated ? 16'h0000 : fp_state.fp_data_selector;
				beat_w.strb = fp_en_r ? `SSAL_S_LEG1_FN : 16'h0000;
			end
			// (RL16) Control/status; (RL17) mask value
			beat_w.data[`SSAL_F_VCS +: 32] = fp_state.simd_ctrl_status;
			beat_w.data[`SSAL_F_VCMASK +: 32] = VCS_VALID;
			if (v128_en_r) begin
				beat_w.strb = beat_w.strb | `SSAL_S_LEG1_V128;
			end
		end else if (idx_r < `SSAL_B_V128L) begin
			// (RL14) Stack register in low 80 bits
			beat_w.data[79:0] = fp_stack_regs[3'(idx_r - `SSAL_B_STK0)];
			beat_w.strb = `SSAL_S_STK;
		end else if (idx_r < `SSAL_B_HDR) begin
			beat_w.data = simd128_regs[4'(idx_r - `SSAL_B_V128L)];
			beat_w.strb = `SSAL_S_FULL;
		end else if (idx_r == `SSAL_B_HDR) begin
			beat_w.data = {cmd_r.compaction_bitmap, cmd_r.req_mask & mask_eff};
			beat_w.strb = `SSAL_S_FULL;
		end else begin
			beat_w.data = simd256_upper_halves[4'(idx_r - `SSAL_B_EXT0)];
			beat_w.strb = `SSAL_S_FULL;
		end
	end

	assign push_w = (state_r == SSAL_RUN) && active_w && fifo_ready;

	ssal_fifo #(
		.WIDTH($bits(ssal_beat_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(push_w),
		.in_ready(fifo_ready),
		.in_data(beat_w),
		.out_valid(mem_valid),
		.out_ready(mem_ready),
		.out_data(mem_beat)
	);

	// (RL16) Reserved control/status bits on restore
	assign bad_vcs = v128_en_r && (idx_r == `SSAL_B_LEG1) &&
		((rsp_data[`SSAL_F_VCS +: 32] & ~VCS_VALID) != 32'h0);

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= SSAL_IDLE;
			idx_r <= 6'h00;
			fault_r <= 1'b0;
		end else begin
			unique case (state_r)
				SSAL_IDLE: begin
					if (cmd_valid) begin
						idx_r <= 6'h00;
						// (RL15) Refused without save-enable
						fault_r <= !save_enable_bit;
						state_r <= save_enable_bit ? SSAL_RUN : SSAL_DONE;
					end
				end
				SSAL_RUN: begin
					if (!active_w || (fifo_ready && cmd_r.op == SSAL_OP_SAVE)) begin
						idx_r <= idx_r + 6'h01;
						state_r <= last_w ? SSAL_DONE : SSAL_RUN;
					end else if (fifo_ready) begin
						state_r <= SSAL_WAIT;
					end
				end
				SSAL_WAIT: begin
					if (rsp_valid) begin
						idx_r <= idx_r + 6'h01;
						fault_r <= bad_vcs;
						state_r <= (last_w || bad_vcs) ? SSAL_DONE : SSAL_RUN;
					end
				end
				SSAL_DONE: begin
					state_r <= SSAL_IDLE;
				end
			endcase
		end
	end

	// Command capture and enables
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cmd_r <= '0;
			ext_loc_r <= 32'h0;
			fp_en_r <= 1'b0;
			v128_en_r <= 1'b0;
			v256_en_r <= 1'b0;
			for (int i = 0; i < NCOMP; i++) begin
				comp_location[i] <= 32'h0;
			end
		end else if (cmd_valid && cmd_ready) begin
			cmd_r <= cmd;
			// (RL2) Extended region starts at component 2
			ext_loc_r <= loc_w[2];
			comp_location <= loc_w;
			// (RL22) Stack state needs mask bit 0, always set
			fp_en_r <= cmd.req_mask[0] && mask_eff[0];
			// (RL19) 128-bit state needs mask bit 1
			v128_en_r <= cmd.req_mask[1] && mask_eff[1];
			// (RL21) (RL3) Wide-vector state needs mask bit 2 and presence
			v256_en_r <= cmd.req_mask[2] && mask_eff[2] &&
				(!cmd.compaction_bitmap[`SSAL_COMPACT_BIT] || cmd.compaction_bitmap[2]);
		end
	end

	// Restore apply
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rest_fp <= '0;
			abr_r <= 8'h00;
			rf_wr_valid <= 1'b0;
			rf_wr_idx <= 6'h00;
			rf_wr_data <= '0;
		end else begin
			rf_wr_valid <= 1'b0;
			if (rsp_fire && !bad_vcs) begin
				rf_wr_idx <= idx_r;
				rf_wr_data <= rsp_data;
				if (idx_r == `SSAL_B_LEG0) begin
					rest_fp.fp_control_word <= rsp_data[`SSAL_F_CTLW +: 16];
					rest_fp.fp_status_word <= rsp_data[`SSAL_F_STSW +: 16];
					rest_fp.fp_last_opcode <= rsp_data[`SSAL_F_OPC +: 16];
					abr_r <= rsp_data[`SSAL_F_TAG +: 8];
					if (cmd_r.wide) begin
						rest_fp.fp_instr_pointer <= rsp_data[`SSAL_F_PTR +: 64];
					end else begin
						rest_fp.fp_instr_pointer <= {32'h0, rsp_data[`SSAL_F_PTR +: 32]};
						// (RL12) Selector ignored when deprecated
						if (!sel_deprecated) begin
							rest_fp.fp_code_selector <= rsp_data[`SSAL_F_SEL +: 16];
						end
					end
				end else if (idx_r == `SSAL_B_LEG1) begin
					if (fp_en_r) begin
						if (cmd_r.wide) begin
							rest_fp.fp_data_pointer <= rsp_data[0 +: 64];
						end else begin
							// (RL13) Data pointer low half and selector
							rest_fp.fp_data_pointer <= {32'h0, rsp_data[0 +: 32]};
							if (!sel_deprecated) begin
								rest_fp.fp_data_selector <= rsp_data[`SSAL_F_SEL1 +: 16];
							end
						end
					end
					// (RL17) Mask field never loaded
					if (v128_en_r) begin
						rest_fp.simd_ctrl_status <= rsp_data[`SSAL_F_VCS +: 32];
					end
				end else begin
					rf_wr_valid <= 1'b1;
					if (idx_r < `SSAL_B_V128L) begin
						// (RL11) Empty or derived tag
						if (!abr_r[3'(idx_r - `SSAL_B_STK0)]) begin
							rest_fp.fp_tag_word[2*(idx_r - `SSAL_B_STK0) +: 2] <= `SSAL_TAG_EMPTY;
						end else if (rsp_data[78:0] == 79'h0) begin
							rest_fp.fp_tag_word[2*(idx_r - `SSAL_B_STK0) +: 2] <= `SSAL_TAG_ZERO;
						end else if (rsp_data[78:64] == `SSAL_EXP_MAX || rsp_data[78:64] == 15'h0) begin
							rest_fp.fp_tag_word[2*(idx_r - `SSAL_B_STK0) +: 2] <= `SSAL_TAG_SPECIAL;
						end else begin
							rest_fp.fp_tag_word[2*(idx_r - `SSAL_B_STK0) +: 2] <= `SSAL_TAG_VALID;
						end
					end
				end
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_refused_cmd;
		cmd_valid && cmd_ready && !save_enable_bit;
	endsequence
	sequence s_fault_done;
		op_done && op_fault;
	endsequence

	a_refuse_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL15
		s_refused_cmd |=> s_fault_done) else $error("disabled command not refused");
	a_header_addr: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL24
		push_w && idx_r == `SSAL_B_HDR |-> beat_w.addr == {cmd_r.base[63:6], 6'h00} + 64'h200)
		else $error("header beat misplaced");
	a_ext_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		cmd_valid && cmd_ready && cmd.compaction_bitmap[63] && cmd.compaction_bitmap[2]
		|=> ext_loc_r == 32'h240) else $error("first compacted component not at 576");
	a_long_only: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL18
		push_w && !cmd_r.long_mode |-> !(idx_r >= `SSAL_B_V128H && idx_r < `SSAL_B_HDR))
		else $error("upper 128-bit registers touched outside 64-bit mode");
	a_upper_half: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL20
		push_w && idx_r >= `SSAL_B_EXT0 |-> (cmd_r.long_mode || idx_r < `SSAL_B_EXT8) && v256_en_r)
		else $error("upper half beat not allowed");
	a_sel_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
		push_w && beat_w.wr && idx_r == `SSAL_B_LEG0 && !cmd_r.wide && sel_deprecated
		|-> beat_w.data[111:96] == 16'h0000) else $error("code selector not zeroed");
	a_stack_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
		push_w && idx_r >= `SSAL_B_STK0 && idx_r < `SSAL_B_V128L
		|-> beat_w.strb == 16'h03ff && beat_w.addr[5:0] == {idx_r[1:0], 4'h0})
		else $error("stack slot strobe wrong");
	a_vcs_fault: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL16
		rsp_fire && bad_vcs |=> op_done && op_fault && $stable(rest_fp.simd_ctrl_status))
		else $error("reserved control/status bit not faulted");
	a_mask_bit0: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL22
		cmd_valid && cmd_ready && save_enable_bit && cmd.req_mask[0] |=> fp_en_r)
		else $error("stack state not selectable");
endmodule

// ===== ssal_mem_model.sv
// Purpose: Load/store path model holding the save area as bytes
// Assumes: One read outstanding, answered in order
// Notes: slow stalls the stream and delays answers
`timescale 1ns/1ps
module ssal_mem_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic mem_valid,
	output logic mem_ready,
	input wire ssal_pkg::ssal_beat_s mem_beat,
	output logic rsp_valid,
	output logic [127:0] rsp_data
);
	import ssal_pkg::*;
	logic [7:0] mem [logic [63:0]];
	logic [1:0] cnt_r;
	logic [1:0] wait_r;
	logic pend_r;
	logic [63:0] ra_r;
	// ********
	// Stream
	// ********
	// Ready one cycle in four when slow
	assign mem_ready = !slow || cnt_r == 2'h0;
	// Store strobed bytes, answer reads
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			pend_r <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= '1;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			rsp_valid <= 1'b0;
			rsp_data <= ~rsp_data; // Released data never holds
			if (mem_valid && mem_ready && mem_beat.wr) begin
				for (int i = 0; i < 16; i++) begin
					if (mem_beat.strb[i]) begin
						mem[mem_beat.addr + 64'(i)] = mem_beat.data[8*i+:8];
					end
				end
			end
			if (mem_valid && mem_ready && !mem_beat.wr) begin
				pend_r <= 1'b1;
				ra_r <= mem_beat.addr;
				wait_r <= slow ? 2'h3 : 2'h0;
			end
			if (pend_r && wait_r != 2'h0) begin
				wait_r <= wait_r - 2'h1;
			end
			if (pend_r && wait_r == 2'h0) begin
				pend_r <= 1'b0;
				rsp_valid <= 1'b1;
				for (int i = 0; i < 16; i++) begin
					rsp_data[8*i+:8] <= mem.exists(ra_r + 64'(i)) ? mem[ra_r + 64'(i)] : 8'ha5;
				end
			end
		end
	end
endmodule

// ===== tb_ssal_layout.sv
// Purpose: Self-checking bench for the save-area layout engine
// Assumes: Model answers every read beat once
// Notes: Saves, then restores the same area
`timescale 1ns/1ps
module tb_ssal_layout;
	import ssal_pkg::*;
	localparam logic [63:0] BASE = 64'h0000000000010000;
	localparam logic [127:0] UNT = {16{8'hxx}};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic slow = 1'b0;
	logic sen = 1'b1;
	logic seld = 1'b0;
	logic cmd_valid = 1'b0;
	logic [63:0] uem = 64'h7;
	logic [31:0] eofs [10];
	logic [31:0] esz [10];
	logic eal [10];
	logic [79:0] stk [8];
	logic [127:0] vlo [16];
	logic [127:0] vhi [16];
	logic [127:0] rfw [64];
	logic [31:0] loc [10];
	logic cmd_ready, mem_valid, mem_ready, rsp_valid, op_done, op_fault, wva, rfv, flt;
	logic [127:0] rsp_data, rfd;
	logic [5:0] rfi;
	logic [63:0] alias_m;
	ssal_cmd_s cmd = '0;
	ssal_fp_s fp, rfp;
	ssal_beat_s beat;
	int num_errors = 0;
	int checks_done = 0;
	always #10 sys_clk = ~sys_clk;
	ssal_layout u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .save_enable_bit(sen),
		.user_state_enable_mask(uem), .sel_deprecated(seld), .enum_offset(eofs),
		.enum_size(esz), .enum_align(eal), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .fp_state(fp), .fp_stack_regs(stk), .simd128_regs(vlo),
		.simd256_upper_halves(vhi), .mem_valid(mem_valid), .mem_ready(mem_ready),
		.mem_beat(beat), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .op_done(op_done),
		.op_fault(op_fault), .wide_vector_allowed(wva), .user_enable_mask_alias(alias_m),
		.comp_location(loc), .rest_fp(rfp), .rf_wr_valid(rfv), .rf_wr_idx(rfi),
		.rf_wr_data(rfd));
	ssal_mem_model u_mem (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
		.mem_valid(mem_valid), .mem_ready(mem_ready), .mem_beat(beat),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));
	// ********
	// Helpers
	// ********
	// Capture restored register beats
	always @(posedge sys_clk) begin
		if (rfv === 1'b1) begin
			rfw[rfi] <= rfd;
		end
	end
	function automatic logic [127:0] rd(input logic [63:0] a, input int n);
		rd = '0;
		for (int i = 0; i < n; i++) begin
			rd[8*i+:8] = u_mem.mem.exists(a + 64'(i)) ? u_mem.mem[a + 64'(i)] : 8'hxx;
		end
	endfunction
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		checks_done++;
		if (g !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			num_errors++;
		end
	endtask
	// One command, then wait for done and a drained stream
	task automatic run(input ssal_op_e op, input logic w, input logic lm, input logic [63:0] bm);
		int n;
		n = 0;
		@(negedge sys_clk);
		cmd = '{op, w, lm, BASE, 64'h7, bm};
		cmd_valid = 1'b1;
		// Ready is looked at where settled; the next rising edge takes the command
		while (cmd_ready !== 1'b1) @(negedge sys_clk);
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (op_done !== 1'b1 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		flt = op_fault;
		while (mem_valid !== 1'b0 && n < 3000) begin
			@(negedge sys_clk);
			n++;
		end
		chk("op_done seen", 1, n < 3000);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ********
	// Watchdog
	// ********
	initial begin
		repeat (20000) @(posedge sys_clk);
		$display("[ERR] watchdog exp done got hang");
		num_errors++;
		end_sim();
	end
	// ********
	// Tests
	// ********
	initial begin
		for (int i = 0; i < 10; i++) begin
			eofs[i] = 32'h0;
			esz[i] = 32'h40;
			eal[i] = 1'b0;
		end
		eofs[2] = 32'h00000300;
		esz[2] = 32'h100;
		esz[5] = 32'h28;
		esz[6] = 32'h64;
		eal[9] = 1'b1;
		for (int i = 0; i < 8; i++) begin
			stk[i] = {16'h4000 + 16'(i), 64'hc000000000000000};
		end
		stk[0] = 80'h0;
		stk[1] = {16'h7fff, 64'h8000000000000000};
		for (int i = 0; i < 16; i++) begin
			vlo[i] = {16{8'(16 + i)}};
			vhi[i] = {16{8'(64 + i)}};
		end
		fp = '{16'h037f, 16'h1234, 16'hffc0, 16'h05a1, 64'h1122334455667788, 16'h0033,
			64'h99aabbccddeeff00, 16'h002b, 32'h00001f80};
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		chk("idle outputs", 3'h1, {op_done, mem_valid, cmd_ready});
		run(SSAL_OP_SAVE, 1'b0, 1'b1, 64'h0);
		chk("ctl sts", {fp.fp_status_word, fp.fp_control_word}, rd(BASE, 4));
		chk("abridged", 8'h07, rd(BASE + 4, 1));
		chk("opcode", fp.fp_last_opcode, rd(BASE + 6, 2));
		chk("ip sel", {fp.fp_code_selector, fp.fp_instr_pointer[31:0]}, rd(BASE + 8, 6));
		chk("dp sel", {fp.fp_data_selector, fp.fp_data_pointer[31:0]}, rd(BASE + 16, 6));
		chk("ctl mask", {32'h0000ffff, fp.simd_ctrl_status}, rd(BASE + 24, 8));
		chk("stack1", stk[1], rd(BASE + 48, 10));
		chk("v128 8", vlo[8], rd(BASE + 288, 16));
		chk("upper 9", vhi[9], rd(BASE + 768 + 144, 16));
		chk("std loc", 32'h300, loc[2]);
		chk("header", {64'h0, 64'h7}, rd(BASE + 512, 16));
		$display("save standard done");
		u_mem.mem[BASE + 28] = 8'hee;
		run(SSAL_OP_RESTORE, 1'b0, 1'b1, 64'h0);
		chk("rest fault", 1'b0, flt);
		chk("rest tags", 16'hffc9, rfp.fp_tag_word);
		chk("rest ip", {32'h0, fp.fp_instr_pointer[31:0]}, rfp.fp_instr_pointer);
		chk("rest sel", fp.fp_code_selector, rfp.fp_code_selector);
		chk("rest ctl", 32'h00001f80, rfp.simd_ctrl_status);
		chk("rest stack0", stk[0], rfw[2][79:0]);
		chk("rest v128 8", vlo[8], rfw[18]);
		chk("rest upper 8", vhi[8], rfw[35]);
		$display("restore done");
		slow = 1'b1;
		u_mem.mem[BASE + 26] = 8'h01;
		run(SSAL_OP_RESTORE, 1'b0, 1'b1, 64'h0);
		chk("bad ctl fault", 1'b1, flt);
		chk("ctl kept", 32'h00001f80, rfp.simd_ctrl_status);
		$display("restore fault done");
		u_mem.mem.delete();
		seld = 1'b1;
		run(SSAL_OP_SAVE, 1'b1, 1'b0, 64'h8000000000000264);
		chk("wide ip", fp.fp_instr_pointer, rd(BASE + 8, 8));
		chk("wide dp", fp.fp_data_pointer, rd(BASE + 16, 8));
		chk("v128 8 kept", UNT, rd(BASE + 288, 16));
		chk("cmp upper0", vhi[0], rd(BASE + 576, 16));
		chk("cmp upper8 kept", UNT, rd(BASE + 704, 16));
		chk("loc2", 32'd576, loc[2]);
		chk("loc5", 32'd832, loc[5]);
		chk("loc6", 32'd872, loc[6]);
		chk("loc9", 32'd1024, loc[9]);
		chk("hdr bitmap", 64'h8000000000000264, rd(BASE + 520, 8));
		$display("save compacted done");
		u_mem.mem.delete();
		slow = 1'b0;
		uem = 64'h4;
		run(SSAL_OP_SAVE, 1'b0, 1'b1, 64'h0);
		chk("mask alias", 64'h5, alias_m);
		chk("wide allowed", 1'b1, wva);
		chk("v128 off", UNT, rd(BASE + 160, 16));
		chk("stack2", stk[2], rd(BASE + 64, 10));
		chk("sel zero", 16'h0000, rd(BASE + 12, 2));
		chk("dsel zero", 16'h0000, rd(BASE + 20, 2));
		$display("mask save done");
		u_mem.mem.delete();
		sen = 1'b0;
		run(SSAL_OP_SAVE, 1'b0, 1'b1, 64'h0);
		chk("off fault", 1'b1, flt);
		chk("off beats", 0, u_mem.mem.num());
		chk("wide refused", 1'b0, wva);
		$display("disabled save done");
		end_sim();
	end
endmodule
